// [sdcti_core.sv]
// Purpose: Command interface of a four-bank 16-bit synchronous DRAM
// Assumes: Controller drives pins for the rising edge of aclk
// Notes: Storage keeps only ROW_KEEP low row bits, so rows alias
`timescale 1ns/1ps
// Behaviour
// - New column command accepted every clock
// - Cut read still gives latency-minus-one words
// - Commands decoded from select and strobe pins
// - Column from low address, high bit closes
// - Two bank bits pick one of four
// - Refresh advances row counter, flagged if a bank is open
// - Enable low enters power-down, suspend or self refresh
// - Burst stop works at every length
// - Write mask blocks same-edge data word
// - Read mask floats output two clocks later
// - Mode word sets latency, length, order
module sdcti_core
	import sdcti_pkg::*;
#(
	parameter int ROW_W = 13,
	parameter int COL_W = 10,
	parameter int ROW_KEEP = 2
)(
	// Clock, reset and freeze
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// AXI4-Lite register port
	input wire logic [REG_AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [REG_AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Memory command and address pins
	input wire logic cke,
	input wire sdcti_pins_t cmd_pins,
	input wire logic [1:0] bank_select_bits,
	input wire logic [ROW_W-1:0] addr,
	input wire logic [1:0] dqm,
	// Data pins, output enable per byte
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out,
	output logic [1:0] dq_oe_n
);
	localparam int MEM_AW = 2 + ROW_KEEP + COL_W;

	logic cke_q;
	logic ctrl_en_q;
	sdcti_mode_t mode_q;
	sdcti_pwr_t pwr_q;
	logic [3:0] open_q;
	logic [ROW_KEEP-1:0] row_q [4];
	logic burst_q;
	logic burst_wr_q;
	logic burst_ap_q;
	logic [1:0] burst_bank_q;
	logic [COL_W-1:0] burst_start_q;
	logic [COL_W-1:0] burst_cnt_q;
	sdcti_word_t pipe_q [3];
	logic [1:0] dqm_p1_q;
	logic [1:0] dqm_p2_q;
	logic [15:0] mem [2**MEM_AW];
	logic [ROW_W-1:0] ref_cnt_q;
	logic [2:0] err_q;
	sdcti_cmd_t cmd;
	logic live;
	logic is_col;
	logic halt;
	logic fetch;
	logic [1:0] ba;
	logic [1:0] lat_pos;
	logic acc_go;
	logic acc_wr;
	logic acc_last;
	logic [1:0] acc_bank;
	logic [COL_W-1:0] acc_n;
	logic [COL_W-1:0] acc_col;
	logic [MEM_AW-1:0] acc_idx;
	logic [7:0] keep_lo;
	sdcti_mode_t mrs_val;
	logic [2:0] err_set;
	logic [2:0] err_clr;
	logic [31:0] status_word;
	logic wr_stb;
	logic [REG_AW-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic [REG_AW-1:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_ok;

	// Last word index of a programmed burst, as a column mask
	function automatic logic [COL_W-1:0] bl_mask(input logic [2:0] blc);
		return (blc == BL_FULL) ? '1 : COL_W'((1 << blc) - 1);
	endfunction

	// Column of word n of a burst, wrapping inside the burst block
	function automatic logic [COL_W-1:0] col_at(input logic [COL_W-1:0] s,
		input logic [COL_W-1:0] n, input sdcti_mode_t m);
		logic [COL_W-1:0] k;
		logic [COL_W-1:0] low;
		k = bl_mask(m.blc);
		low = m.il ? (s ^ n) : COL_W'(s + n);
		return (s & ~k) | (low & k);
	endfunction

	// Register bus slave
	sdcti_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.clk_en(clk_en),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wr_stb(wr_stb),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok(wr_ok),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	assign live = clk_en && cke_q;
	assign cmd = ctrl_en_q ? cmd_decode(cmd_pins) : CMD_DESEL;
	assign ba = bank_idx(bank_select_bits);
	assign is_col = (cmd == CMD_RD) || (cmd == CMD_WR);
	assign halt = (cmd == CMD_BST) || ((cmd == CMD_PRE)
		&& (addr[AP_BIT] || ba == burst_bank_q));
	assign lat_pos = (mode_q.lat >= 3'h1 && mode_q.lat <= 3'h3) ?
		2'(mode_q.lat - 3'h1) : 2'h2;

	always_comb
	begin
		acc_go = 1'b0;
		acc_wr = 1'b0;
		acc_bank = burst_bank_q;
		acc_n = '0;
		acc_col = '0;
		if (is_col)
		begin
			acc_go = 1'b1;
			acc_wr = (cmd == CMD_WR);
			acc_bank = ba;
			acc_col = addr[COL_W-1:0];
		end
		else if (burst_q && !halt)
		begin
			acc_go = 1'b1;
			acc_wr = burst_wr_q;
			acc_n = burst_cnt_q + 1'b1;
			acc_col = col_at(burst_start_q, acc_n, mode_q);
		end
		acc_last = (mode_q.blc != BL_FULL) && (acc_n == bl_mask(mode_q.blc));
	end
	assign acc_idx = {acc_bank, row_q[acc_bank], acc_col};
	assign fetch = live && acc_go && !acc_wr;
	assign keep_lo = mem[acc_idx][7:0];

	// Burst tracking
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			burst_q <= 1'b0;
			burst_wr_q <= 1'b0;
			burst_ap_q <= 1'b0;
			burst_bank_q <= 2'h0;
			burst_start_q <= '0;
			burst_cnt_q <= '0;
		end
		else if (live)
		begin
			burst_q <= acc_go && !acc_last;
			if (acc_go)
				burst_cnt_q <= acc_n;
			if (is_col)
			begin
				burst_wr_q <= (cmd == CMD_WR);
				burst_bank_q <= ba;
				burst_start_q <= addr[COL_W-1:0];
				burst_ap_q <= addr[AP_BIT];
			end
		end
	end

	// Bank open state and latched rows
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			open_q <= 4'h0;
			for (int b = 0; b < 4; b++)
				row_q[b] <= '0;
		end
		else if (live)
		begin
			if (acc_go && acc_last && (is_col ? addr[AP_BIT] : burst_ap_q))
				open_q[acc_bank] <= 1'b0;
			if (cmd == CMD_ACT)
			begin
				open_q[ba] <= 1'b1;
				row_q[ba] <= addr[ROW_KEEP-1:0];
			end
			else if (cmd == CMD_PRE && addr[AP_BIT])
				open_q <= 4'h0;
			else if (cmd == CMD_PRE)
				open_q[ba] <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (aresetn && live && acc_go && acc_wr)
			for (int b = 0; b < 2; b++)
				if (!dqm[b])
					mem[acc_idx][8*b +: 8] <= dq_in[8*b +: 8];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			for (int k = 0; k < 3; k++)
				pipe_q[k] <= WORD_IDLE;
		else if (live)
		begin
			pipe_q[2] <= (fetch && lat_pos == 2'h2) ?
				sdcti_word_t'{v: 1'b1, d: mem[acc_idx]} : WORD_IDLE;
			for (int k = 0; k < 2; k++)
				pipe_q[k] <= (fetch && lat_pos == 2'(k)) ?
					sdcti_word_t'{v: 1'b1, d: mem[acc_idx]} : pipe_q[k+1];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dqm_p1_q <= 2'h3;
			dqm_p2_q <= 2'h3;
		end
		else if (clk_en)
		begin
			dqm_p1_q <= dqm;
			dqm_p2_q <= dqm_p1_q;
		end
	end
	assign dq_out = pipe_q[0].d;
	assign dq_oe_n = ~({2{pipe_q[0].v}} & ~dqm_p2_q);

	assign mrs_val = '{lat: addr[MR_CL_LSB +: 3], il: addr[MR_BT_BIT],
		blc: addr[MR_BL_LSB +: 3]};
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mode_q <= MODE_RST;
		else if (live && cmd == CMD_MRS && open_q == 4'h0 && !burst_q)
			mode_q <= mrs_val;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cke_q <= 1'b1;
			pwr_q <= PW_RUN;
		end
		else if (clk_en)
		begin
			cke_q <= cke;
			if (cke_q && !cke && cmd == CMD_REF)
				pwr_q <= PW_SELF;
			else if (cke_q && !cke && acc_go && !acc_last)
				pwr_q <= PW_SUSP;
			else if (cke_q && !cke && open_q != 4'h0)
				pwr_q <= PW_ACT_PD;
			else if (cke_q && !cke)
				pwr_q <= PW_PRE_PD;
			else if (!cke_q && cke)
				pwr_q <= PW_RUN;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ref_cnt_q <= '0;
		else if (live && cmd == CMD_REF)
			ref_cnt_q <= ref_cnt_q + 1'b1;
	end

	// misuse flags, set wins over clear
	assign err_set[ERR_MRS_BIT] = live && cmd == CMD_MRS && open_q != 4'h0;
	assign err_set[ERR_REF_BIT] = live && cmd == CMD_REF && open_q != 4'h0;
	assign err_set[ERR_COL_BIT] = live && is_col && !open_q[ba];
	assign err_clr = (wr_stb && wr_addr == REG_ERR && wr_strb[0]) ?
		wr_data[2:0] : 3'h0;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			err_q <= 3'h0;
		else if (clk_en)
			err_q <= (err_q & ~err_clr) | err_set;
	end

	// Control register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_en_q <= CTRL_EN_RST;
		else if (wr_stb && wr_addr == REG_CTRL && wr_strb[0])
			ctrl_en_q <= wr_data[CTRL_EN_BIT];
	end

	// Register read decode
	assign status_word = (32'(open_q) << ST_OPEN_LSB)
		| (32'(burst_q) << ST_BURST_BIT) | (32'(pwr_q) << ST_PWR_LSB)
		| (32'(mode_q.lat) << ST_CL_LSB) | (32'(mode_q.il) << ST_BT_BIT)
		| (32'(mode_q.blc) << ST_BL_LSB);
	assign wr_ok = (wr_addr == REG_CTRL) || (wr_addr == REG_STATUS)
		|| (wr_addr == REG_REFCNT) || (wr_addr == REG_ERR);
	always_comb
	begin
		rd_ok = 1'b1;
		case (rd_addr)
			REG_CTRL: rd_data = 32'(ctrl_en_q) << CTRL_EN_BIT;
			REG_STATUS: rd_data = status_word;
			REG_REFCNT: rd_data = 32'(ref_cnt_q);
			REG_ERR: rd_data = 32'(err_q);
			default:
			begin
				rd_data = 32'h0000_0000;
				rd_ok = 1'b0;
			end
		endcase
	end

	// Checks on the pin-level behaviour
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_rd_pair;
		live && cmd == CMD_RD && mode_q.lat == 3'h1 ##1 live && cmd == CMD_RD;
	endsequence
	sequence s_rd_run3;
		fetch && mode_q.lat == 3'h3 ##1 fetch;
	endsequence
	sequence s_cut;
		live && burst_q && !burst_wr_q && halt && !is_col;
	endsequence

	col_every_a: assert property (s_rd_pair |=> pipe_q[0].v
		&& $past(pipe_q[0].v))
		else $error("back to back column read lost a word");
	cut_tail_a: assert property (s_rd_run3 ##1 s_cut ##1 live[*2]
		|-> pipe_q[0].v && $past(pipe_q[0].v) ##1 !pipe_q[0].v)
		else $error("cut read burst gave wrong word count");
	act_decode_a: assert property (live && ctrl_en_q
		&& cmd_pins == 4'h3 |=> open_q[$past(ba)])
		else $error("activate pattern did not open bank");
	pre_all_a: assert property (live && cmd == CMD_PRE
		&& addr[AP_BIT] |=> open_q == 4'h0)
		else $error("all-bank precharge left a bank open");
	bank_b_a: assert property (live && cmd == CMD_ACT
		&& bank_select_bits == 2'h2 |=> open_q[1])
		else $error("bank bits 10 did not select bank B");
	ref_count_a: assert property (live && cmd == CMD_REF
		|=> ref_cnt_q == $past(ref_cnt_q) + 1'b1)
		else $error("refresh did not advance row counter");
	self_entry_a: assert property (clk_en && cke_q && !cke
		&& cmd == CMD_REF |=> pwr_q == PW_SELF)
		else $error("refresh with enable low missed self refresh");
	pd_entry_a: assert property (clk_en && cke_q && !cke
		&& cmd == CMD_NOP && open_q == 4'h0 && !burst_q
		|=> pwr_q == PW_PRE_PD ##1 (!clk_en || pwr_q != PW_RUN || cke_q))
		else $error("idle enable drop missed precharge power-down");
	stop_any_a: assert property (live && burst_q
		&& cmd == CMD_BST |=> !burst_q)
		else $error("burst stop ignored");
	wmask_zero_a: assert property (live && acc_go && acc_wr
		&& dqm[0] |=> mem[$past(acc_idx)][7:0] == $past(keep_lo))
		else $error("masked write byte changed memory");
	rmask_two_a: assert property (clk_en && dqm[0] ##1 clk_en
		|=> dq_oe_n[0])
		else $error("read mask did not float byte after two clocks");
	mode_load_a: assert property (live && cmd == CMD_MRS
		&& open_q == 4'h0 && !burst_q |=> mode_q == $past(mrs_val))
		else $error("mode word not loaded");
endmodule // sdcti_core

// [sdcti_pkg.sv]
// Purpose: Shared constants, types and decoders of the SDRAM command block
// Assumes: One 50 MHz clock; every memory pin is sampled on its rising edge
// Notes: Interval figures are what the external controller has to respect
package sdcti_pkg;
	// Clock period in ps
	localparam int CLK_PERIOD_PS = 20000;
	// Controller-side intervals, figures in ns, us and ms
	localparam int T_RRD_NS = 16;
	localparam int T_RRD_SLOW_NS = 20;
	localparam int T_RCD_NS = 20;
	localparam int T_RP_NS = 20;
	localparam int T_RAS_NS = 48;
	localparam int T_RAS_MAX_US = 100;
	localparam int T_RC_NS = 68;
	localparam int T_REF_PERIOD_MS = 64;
	localparam int REF_ROWS = 8192;
	// Least time in ns to whole clocks, rounded up, never below one
	function automatic int ns_up(input int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int T_RRD_CYC = ns_up(T_RRD_NS);
	localparam int T_RRD_SLOW_CYC = ns_up(T_RRD_SLOW_NS);
	localparam int T_RCD_CYC = ns_up(T_RCD_NS);
	localparam int T_RP_CYC = ns_up(T_RP_NS);
	localparam int T_RAS_CYC = ns_up(T_RAS_NS);
	localparam int T_RC_CYC = ns_up(T_RC_NS);
	// Counts given directly in clocks
	localparam int T_RDL_CYC = 2;
	localparam int T_RDL_SLOW_CYC = 1;
	localparam int T_DAL_CYC = T_RDL_CYC + T_RP_CYC;
	localparam int WRITE_TO_COLUMN_GAP = 1;
	localparam int WRITE_TO_BURST_HALT_GAP = 1;
	localparam int T_CCD_CYC = 1;
	localparam int MRS_GAP_CYC = 2;
	// Register map, byte addresses on an 8-bit AXI4-Lite address
	localparam int REG_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_REFCNT = 8'h08;
	localparam logic [7:0] REG_ERR = 8'h0C;
	localparam int CTRL_EN_BIT = 0;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam int ST_OPEN_LSB = 0;
	localparam int ST_BURST_BIT = 4;
	localparam int ST_PWR_LSB = 5;
	localparam int ST_CL_LSB = 8;
	localparam int ST_BT_BIT = 11;
	localparam int ST_BL_LSB = 12;
	localparam int ERR_MRS_BIT = 0;
	localparam int ERR_REF_BIT = 1;
	localparam int ERR_COL_BIT = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Mode word fields on the address pins
	localparam int MR_BL_LSB = 0;
	localparam int MR_BT_BIT = 3;
	localparam int MR_CL_LSB = 4;
	localparam int AP_BIT = 10;
	localparam logic [2:0] BL_FULL = 3'h7;
	typedef struct packed {
		logic [2:0] lat;
		logic il;
		logic [2:0] blc;
	} sdcti_mode_t;
	localparam sdcti_mode_t MODE_RST = '{lat: 3'h3, il: 1'b0, blc: 3'h0};
	// Command pins and one read pipeline word
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} sdcti_pins_t;
	typedef struct packed {
		logic v;
		logic [15:0] d;
	} sdcti_word_t;
	localparam sdcti_word_t WORD_IDLE = '{v: 1'b0, d: 16'h0000};
	typedef enum {CMD_MRS, CMD_REF, CMD_ACT, CMD_RD, CMD_WR, CMD_BST,
		CMD_PRE, CMD_NOP, CMD_DESEL} sdcti_cmd_t;
	typedef enum logic [2:0] {PW_RUN, PW_PRE_PD, PW_ACT_PD, PW_SUSP,
		PW_SELF} sdcti_pwr_t;
	// Pin pattern to command
	function automatic sdcti_cmd_t cmd_decode(input sdcti_pins_t p);
		sdcti_cmd_t c;
		c = CMD_NOP;
		unique case ({p.ras_n, p.cas_n, p.we_n})
			3'h0: c = CMD_MRS;
			3'h1: c = CMD_REF;
			3'h2: c = CMD_PRE;
			3'h3: c = CMD_ACT;
			3'h4: c = CMD_WR;
			3'h5: c = CMD_RD;
			3'h6: c = CMD_BST;
			3'h7: c = CMD_NOP;
		endcase
		return p.cs_n ? CMD_DESEL : c;
	endfunction
	// Bank pins to bank index A=0 B=1 C=2 D=3
	function automatic logic [1:0] bank_idx(input logic [1:0] ba);
		return {ba[0], ba[1]};
	endfunction
endpackage

// [sdcti_axil.sv]
// Purpose: AXI4-Lite slave front end for the SDRAM command block registers
// Assumes: One write and one read under way at a time
// Notes: Write answers two cycles after the later of address and data
`timescale 1ns/1ps
module sdcti_axil
	import sdcti_pkg::*;
(
	// Clock, reset, freeze
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// Write channels
	input wire logic [REG_AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read channels
	input wire logic [REG_AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Register side
	output logic wr_stb,
	output logic [REG_AW-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_ok,
	output logic [REG_AW-1:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok
);
	logic aw_have_q;
	logic w_have_q;
	logic bvalid_q;
	logic rvalid_q;
	logic [REG_AW-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	// Each write channel is taken once and held until the write is done
	assign awready = clk_en && !aw_have_q && !bvalid_q;
	assign wready = clk_en && !w_have_q && !bvalid_q;
	assign arready = clk_en && !rvalid_q;
	assign wr_stb = clk_en && aw_have_q && w_have_q;
	assign wr_addr = awaddr_q;
	assign wr_data = wdata_q;
	assign wr_strb = wstrb_q;
	assign rd_addr = araddr;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// Write address, data and response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bresp_q <= RESP_OKAY;
		end
		else if (clk_en)
		begin
			if (awvalid && awready)
			begin
				aw_have_q <= 1'b1;
				awaddr_q <= awaddr;
			end
			else if (wr_stb)
				aw_have_q <= 1'b0;
			if (wvalid && wready)
			begin
				w_have_q <= 1'b1;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			else if (wr_stb)
				w_have_q <= 1'b0;
			if (wr_stb)
			begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bready)
				bvalid_q <= 1'b0;
		end
	end

	// Read answer one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end
		else if (clk_en)
		begin
			if (arvalid && arready)
			begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_data;
				rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rready)
				rvalid_q <= 1'b0;
		end
	end
endmodule // sdcti_axil

// [sdcti_ctrl_model.sv]
// Purpose: Controller model that drives the memory command pins
// Assumes: Tasks are entered just after a rising edge
// Notes: Released data lines carry the inverse of the last word
`timescale 1ns/1ps
module sdcti_ctrl_model
	import sdcti_pkg::*;
(
	// Clock
	input wire logic aclk,
	// Memory pins
	output logic cke,
	output sdcti_pins_t cmd_pins,
	output logic [1:0] bank_select_bits,
	output logic [12:0] addr,
	output logic [1:0] dqm,
	output logic [15:0] dq_in
);
	// Idle pins at time zero
	initial
	begin
		cke = 1'b1;
		cmd_pins = 4'h7;
		bank_select_bits = 2'h0;
		addr = 13'h0000;
		dqm = 2'h0;
		dq_in = 16'h0000;
	end
	// recovery and refresh kept by caller
	task automatic op(input logic [2:0] rcw, input logic [1:0] ba,
		input logic [12:0] a, input logic [15:0] d, input logic [1:0] m,
		input int gap);
		cmd_pins <= {1'b0, rcw};
		bank_select_bits <= ba;
		addr <= a;
		dq_in <= d;
		dqm <= m;
		@(posedge aclk);
		if (gap > 0)
		begin
			cmd_pins <= 4'h7;
			dq_in <= ~d;
			dqm <= 2'h0;
			repeat (gap) @(posedge aclk);
		end
	endtask
	task automatic set_cke(input logic v, input logic [2:0] rcw);
		cke <= v;
		cmd_pins <= {1'b0, rcw};
		@(posedge aclk);
	endtask
endmodule // sdcti_ctrl_model

// [test_sdram_command_timing_interface.sv]
// Purpose: Self-checking bench of the SDRAM command block
// Assumes: Controller model drives the memory pins
// Notes: Register reads from a table, pin cases by hand
`timescale 1ns/1ps
module test_sdram_command_timing_interface
	import sdcti_pkg::*;
;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic [1:0] r;
	} sdcti_row_t;
	localparam logic [31:0] ST0 = 32'h0000_0300;
	localparam logic [31:0] ST2 = 32'h0000_1200;
	sdcti_row_t rows [5] = '{'{REG_CTRL, 32'h0000_0001, RESP_OKAY},
		'{REG_STATUS, ST0, RESP_OKAY}, '{REG_REFCNT, 32'h0, RESP_OKAY},
		'{REG_ERR, 32'h0, RESP_OKAY}, '{8'h10, 32'h0, RESP_SLVERR}};
	logic [1:0] bsel [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
	logic aclk, aresetn, clk_en, cke;
	logic [7:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata, rd_v;
	logic [3:0] wstrb, open_exp;
	logic [1:0] bresp, rresp, dqm, bank_select_bits, dq_oe_n, rd_r;
	sdcti_pins_t cmd_pins;
	logic [12:0] addr;
	logic [15:0] dq_in, dq_out;
	int err_count = 0;
	int comparisons = 0;
	// Design and controller model
	sdcti_core u_dut (.aclk, .aresetn, .clk_en, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cke,
		.cmd_pins, .bank_select_bits, .addr, .dqm, .dq_in, .dq_out, .dq_oe_n);
	sdcti_ctrl_model u_ctrl (.aclk, .cke, .cmd_pins, .bank_select_bits,
		.addr, .dqm, .dq_in);
	// Clock
	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("%0d comparisons, %0d mismatches", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic bound(input int n);
		if (n >= 50)
		begin
			err_count++;
			print_verdict();
		end
	endtask
	task automatic axi_read(input logic [7:0] a);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (arready !== 1'b1 && n < 50);
		arvalid <= 1'b0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (rvalid !== 1'b1 && n < 50);
		rd_v = rdata;
		rd_r = rresp;
		bound(n);
	endtask
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ao, wo;
		n = 0;
		ao = 1'b0;
		wo = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			ao = ao | (awready === 1'b1);
			wo = wo | (wready === 1'b1);
			if (ao)
				awvalid <= 1'b0;
			if (wo)
				wvalid <= 1'b0;
		end
		while (!(ao && wo) && n < 50);
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (bvalid !== 1'b1 && n < 50);
		rd_r = bresp;
		bound(n);
	endtask
	// Main sequence
	initial
	begin
		{aresetn, awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
		clk_en = 1'b1;
		wstrb = 4'hF;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i])
		begin
			axi_read(rows[i].a);
			check(rd_v, rows[i].d);
			check({30'h0, rd_r}, {30'h0, rows[i].r});
		end
		$display("register table done");
		u_ctrl.op(3'h0, 2'h0, 13'h0021, 16'h0, 2'h0, MRS_GAP_CYC);
		axi_read(REG_STATUS);
		check(rd_v, ST2);
		open_exp = 4'h0;
		for (int b = 0; b < 4; b++)
		begin
			u_ctrl.op(3'h3, bsel[b], 13'h0005, 16'h0, 2'h0, T_RRD_CYC);
			open_exp = open_exp | (4'h1 << b);
			axi_read(REG_STATUS);
			check(rd_v, ST2 | {28'h000_0000, open_exp});
		end
		u_ctrl.op(3'h2, 2'h1, 13'h0400, 16'h0, 2'h0, T_RP_CYC);
		axi_read(REG_STATUS);
		check(rd_v, ST2);
		axi_write(REG_CTRL, 32'h0);
		u_ctrl.op(3'h3, 2'b10, 13'h0005, 16'h0, 2'h0, T_RCD_CYC);
		axi_read(REG_STATUS);
		check(rd_v, ST2);
		axi_write(REG_CTRL, 32'h0000_0001);
		check({30'h0, rd_r}, {30'h0, RESP_OKAY});
		axi_write(8'h20, 32'h0000_0001);
		check({30'h0, rd_r}, {30'h0, RESP_SLVERR});
		$display("mode, bank and register writes done");
		u_ctrl.op(3'h3, 2'b10, 13'h0005, 16'h0, 2'h0, T_RCD_CYC - 1);
		u_ctrl.op(3'h4, 2'b10, 13'h0000, 16'h1234, 2'h0, 0);
		u_ctrl.op(3'h7, 2'b10, 13'h0000, 16'h5678, 2'h0, 0);
		u_ctrl.op(3'h4, 2'b10, 13'h0000, 16'habcd, 2'h1, 0);
		u_ctrl.op(3'h7, 2'b10, 13'h0000, 16'hef01, 2'h2, T_RDL_CYC);
		u_ctrl.op(3'h5, 2'b10, 13'h0000, 16'h0, 2'h0, 1);
		@(posedge aclk);
		check({16'h0, dq_out}, 32'h0000_ab34);
		check({30'h0, dq_oe_n}, 32'h0);
		@(posedge aclk);
		check({16'h0, dq_out}, 32'h0000_5601);
		@(posedge aclk);
		check({30'h0, dq_oe_n}, 32'h3);
		u_ctrl.op(3'h5, 2'b10, 13'h0000, 16'h0, 2'h0, 0);
		u_ctrl.op(3'h7, 2'b10, 13'h0000, 16'h0, 2'h1, 1);
		@(posedge aclk);
		check({30'h0, dq_oe_n}, 32'h1);
		check({24'h00_0000, dq_out[15:8]}, 32'h0000_0056);
		u_ctrl.op(3'h5, 2'b10, 13'h0000, 16'h0, 2'h0, 0);
		u_ctrl.op(3'h6, 2'b10, 13'h0000, 16'h0, 2'h0, 1);
		check({30'h0, dq_oe_n}, 32'h0);
		@(posedge aclk);
		check({30'h0, dq_oe_n}, 32'h3);
		$display("write and read bursts done");
		u_ctrl.op(3'h2, 2'b10, 13'h0000, 16'h0, 2'h0, T_RP_CYC);
		u_ctrl.op(3'h1, 2'h0, 13'h0000, 16'h0, 2'h0, T_RC_CYC);
		axi_read(REG_REFCNT);
		check(rd_v, 32'h0000_0001);
		axi_read(REG_ERR);
		check(rd_v, 32'h0);
		u_ctrl.set_cke(1'b0, 3'h7);
		axi_read(REG_STATUS);
		check(rd_v, ST2 | 32'h0000_0020);
		u_ctrl.set_cke(1'b1, 3'h7);
		axi_read(REG_STATUS);
		check(rd_v, ST2);
		u_ctrl.set_cke(1'b0, 3'h1);
		axi_read(REG_STATUS);
		check(rd_v, ST2 | 32'h0000_0080);
		u_ctrl.set_cke(1'b1, 3'h7);
		axi_read(REG_REFCNT);
		check(rd_v, 32'h0000_0002);
		$display("self refresh done");
		u_ctrl.op(3'h0, 2'h0, 13'h0011, 16'h0, 2'h0, MRS_GAP_CYC);
		u_ctrl.op(3'h3, 2'b10, 13'h0005, 16'h0, 2'h0, T_RCD_CYC - 1);
		u_ctrl.op(3'h5, 2'b10, 13'h0000, 16'h0, 2'h0, 0);
		u_ctrl.op(3'h5, 2'b10, 13'h0001, 16'h0, 2'h0, 1);
		check({16'h0, dq_out}, 32'h0000_5601);
		@(posedge aclk);
		check({16'h0, dq_out}, 32'h0000_ab34);
		u_ctrl.op(3'h2, 2'b10, 13'h0000, 16'h0, 2'h0, T_RP_CYC);
		u_ctrl.op(3'h0, 2'h0, 13'h0031, 16'h0, 2'h0, MRS_GAP_CYC);
		u_ctrl.op(3'h3, 2'b10, 13'h0005, 16'h0, 2'h0, T_RCD_CYC - 1);
		u_ctrl.op(3'h5, 2'b10, 13'h0000, 16'h0, 2'h0, 0);
		u_ctrl.op(3'h5, 2'b10, 13'h0001, 16'h0, 2'h0, 0);
		u_ctrl.op(3'h6, 2'b10, 13'h0000, 16'h0, 2'h0, 1);
		check({16'h0, dq_out}, 32'h0000_ab34);
		@(posedge aclk);
		check({16'h0, dq_out}, 32'h0000_5601);
		@(posedge aclk);
		check({30'h0, dq_oe_n}, 32'h3);
		u_ctrl.op(3'h0, 2'h0, 13'h0021, 16'h0, 2'h0, MRS_GAP_CYC);
		axi_read(REG_ERR);
		check(rd_v, 32'h0000_0001);
		axi_write(REG_ERR, 32'h0000_0001);
		axi_read(REG_ERR);
		check(rd_v, 32'h0);
		$display("latency and misuse cases done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(REG_STATUS);
		check(rd_v, ST0);
		$display("refresh, power and reset done");
		print_verdict();
	end
endmodule // test_sdram_command_timing_interface
